// >>> hdl/sapp_defs.svh
// constants of the converter host port
// assumes a 10 MHz clock; included by the bus map and port design files
`ifndef SAPP_DEFS_SVH
`define SAPP_DEFS_SVH
`define SAPP_CLK_NS        100
`define SAPP_CONV_NS       8000
`define SAPP_CONV_CYC      ((`SAPP_CONV_NS + `SAPP_CLK_NS - 1) / `SAPP_CLK_NS)
`define SAPP_BUSY_DLY_NS   200
`define SAPP_BUSY_DLY_CYC  ((`SAPP_BUSY_DLY_NS + `SAPP_CLK_NS - 1) / `SAPP_CLK_NS)
`define SAPP_RES_W         12
`define SAPP_BUS_W         16
`define SAPP_PAD_W         4
`define SAPP_BYTE_W        8
`define SAPP_RES_MSB       11
`define SAPP_RES_RST       12'h000
`endif

// >>> hdl/sapp_pkg.sv
// types of the converter host port
// assumes sapp_defs.svh is compiled alongside
package sapp_pkg;
    typedef enum logic [1:0] {SAPP_IDLE, SAPP_CONV, SAPP_SETTLE} sapp_state_t;
endpackage

// >>> hdl/sapp_sync.sv
// two flip-flop synchroniser for one pin
// assumes the pin is asynchronous to clock
module sapp_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // pin and synchronised level
    input  wire logic pin,
    output logic      level
);
    logic stage1;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            stage1 <= RESET_VALUE;
            level  <= RESET_VALUE;
        end
        else
        begin
            stage1 <= pin;
            level  <= stage1;
        end
    end
endmodule

// >>> hdl/sapp_bus_map.sv
// maps the held result onto the 16-line bus
// assumes a two's complement result word from the conversion core
`include "sapp_defs.svh"
module sapp_bus_map (
    // result and byte choice
    input  wire logic [`SAPP_RES_W-1:0] result,
    input  wire logic                   byteLow,
    // bus value
    output logic      [`SAPP_BUS_W-1:0] busValue
);
    logic [`SAPP_BUS_W-1:0] full;

    // result above four grounded pad lines
    assign full = {result, {`SAPP_PAD_W{1'b0}}};

    // low byte copied onto the upper byte when byte-select is high;
    // the lower byte keeps its place so the pad lines stay low in both modes
    assign busValue = byteLow
        ? {full[`SAPP_BYTE_W-1:0], full[`SAPP_BYTE_W-1:0]}
        : full;
endmodule

// >>> hdl/sapp_port.sv
// convert control and parallel read-out of a 12-bit converter
// assumes host pins are asynchronous; sample word comes from the analog core
`include "sapp_defs.svh"
module sapp_port #(
    parameter int CONV_CYCLES = `SAPP_CONV_CYC,
    parameter int BUSY_DELAY  = `SAPP_BUSY_DLY_CYC
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset,
    // host control pins
    input  wire logic                   selectN,
    input  wire logic                   readConvert,
    input  wire logic                   byteSelect,
    // analog core sample
    input  wire logic [`SAPP_RES_W-1:0] sample,
    // host status and data pins
    output logic                        busyN,
    output logic [`SAPP_BUS_W-1:0]      dataOut,
    output logic [`SAPP_BUS_W-1:0]      dataOe
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic selSync;
    logic rcSync;
    logic byteSync;

    sapp_sync #(.RESET_VALUE(1'b1)) u_selSync (
        .clock (clock), .reset (reset), .pin (selectN), .level (selSync));
    sapp_sync #(.RESET_VALUE(1'b1)) u_rcSync (
        .clock (clock), .reset (reset), .pin (readConvert), .level (rcSync));
    sapp_sync #(.RESET_VALUE(1'b0)) u_byteSync (
        .clock (clock), .reset (reset), .pin (byteSelect), .level (byteSync));

    // ------------------------------------------------------------
    // start detection
    // ------------------------------------------------------------
    logic convReq;
    logic convReqPrev;
    logic startPulse;
    logic readEnable;

    // select and read/convert are or'd: low together means convert
    assign convReq    = ~selSync & ~rcSync;
    assign readEnable = ~selSync & rcSync;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            convReqPrev <= 1'b0;
        else
            convReqPrev <= convReq;
    end

    sapp_pkg::sapp_state_t state;
    // edge of the combined request starts only while idle and busy is high again
    assign startPulse = convReq & ~convReqPrev & busyN
                      & (state == sapp_pkg::SAPP_IDLE);

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    localparam int CW = $clog2(CONV_CYCLES + BUSY_DELAY + 1);
    logic [CW-1:0] count;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state <= sapp_pkg::SAPP_IDLE;
            count <= '0;
        end
        else
        begin
            unique case (state)
                sapp_pkg::SAPP_IDLE:
                begin
                    if (startPulse)
                    begin
                        state <= sapp_pkg::SAPP_CONV;
                        count <= CW'(CONV_CYCLES - 1);
                    end
                end
                sapp_pkg::SAPP_CONV:
                begin
                    if (count == '0)
                    begin
                        state <= sapp_pkg::SAPP_SETTLE;
                        count <= CW'(BUSY_DELAY - 1);
                    end
                    else
                        count <= count - CW'(1);
                end
                sapp_pkg::SAPP_SETTLE:
                begin
                    if (count == '0)
                        state <= sapp_pkg::SAPP_IDLE;
                    else
                        count <= count - CW'(1);
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // result latch
    // ------------------------------------------------------------
    logic [`SAPP_RES_W-1:0] heldSample;
    logic [`SAPP_RES_W-1:0] result;
    logic                   convDone;

    assign convDone = (state == sapp_pkg::SAPP_CONV) && (count == '0);

    // sample is frozen at the start, published at the end of conversion
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            heldSample <= `SAPP_RES_RST;
        else if (startPulse)
            heldSample <= sample;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            result <= `SAPP_RES_RST;
        else if (convDone)
            result <= heldSample;
    end

    // ------------------------------------------------------------
    // busy output
    // ------------------------------------------------------------
    logic next_busyN;

    // low from the start, and for BUSY_DELAY + 1 cycles from when the latch holds the new word
    assign next_busyN = (state == sapp_pkg::SAPP_IDLE) ? ~startPulse : 1'b0;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            busyN <= 1'b1;
        else
            busyN <= next_busyN;
    end

    // ------------------------------------------------------------
    // data bus drivers
    // ------------------------------------------------------------
    logic [`SAPP_BUS_W-1:0] busValue;

    sapp_bus_map u_map (
        .result   (result),
        .byteLow  (byteSync),
        .busValue (busValue)
    );

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            dataOut <= '0;
            dataOe  <= '0;
        end
        else
        begin
            dataOut <= busValue;
            dataOe  <= {`SAPP_BUS_W{readEnable}};
        end
    end

    // ------------------------------------------------------------
    // busy span watch
    // ------------------------------------------------------------
    localparam int BUSY_SPAN = CONV_CYCLES + BUSY_DELAY + 1;
    logic [CW:0] busyLowCount;

    // counts the cycles busy has stood low, read only by the span check
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            busyLowCount <= '0;
        else if (busyN)
            busyLowCount <= '0;
        else
            busyLowCount <= busyLowCount + (CW+1)'(1);
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_start;
        startPulse;
    endsequence

    sequence s_busyHeld;
        !busyN [*8];
    endsequence

    sequence s_busyEnds;
        $rose(busyN);
    endsequence

    sequence s_latchIdle;
        !convDone;
    endsequence

    sequence s_freshReq;
        convReq && !$past(convReq) && busyN;
    endsequence

    a_float_when_idle: assert property (
        @(posedge clock) disable iff (reset)
        !readEnable |=> dataOe == '0)
        else $error("bus driven while not reading");

    a_drive_when_read: assert property (
        @(posedge clock) disable iff (reset)
        readEnable |=> dataOe == '1)
        else $error("bus not driven while reading");

    a_pad_low: assert property (
        @(posedge clock) disable iff (reset)
        dataOut[`SAPP_PAD_W-1:0] == '0)
        else $error("pad lines not low");

    a_word_order: assert property (
        @(posedge clock) disable iff (reset)
        !byteSync |=> dataOut[`SAPP_BUS_W-1:`SAPP_PAD_W] == $past(result))
        else $error("full word misplaced");

    a_byte_swap: assert property (
        @(posedge clock) disable iff (reset)
        byteSync |=> dataOut[`SAPP_BUS_W-1:`SAPP_BYTE_W]
                     == {$past(result[3:0]), {`SAPP_PAD_W{1'b0}}})
        else $error("low byte misplaced");

    a_busy_falls: assert property (
        @(posedge clock) disable iff (reset)
        s_start |=> s_busyHeld)
        else $error("busy not held low after start");

    a_no_restart: assert property (
        @(posedge clock) disable iff (reset)
        !busyN |-> !startPulse)
        else $error("start accepted while busy");

    a_latch_before_busy: assert property (
        @(posedge clock) disable iff (reset)
        $rose(busyN) |-> $past(result) == result && $past(state, 2)
                         == sapp_pkg::SAPP_SETTLE)
        else $error("busy rose before latch settled");

    a_old_result: assert property (
        @(posedge clock) disable iff (reset)
        s_start |=> $stable(result))
        else $error("result changed at start");

    a_busy_span: assert property (
        @(posedge clock) disable iff (reset)
        s_busyEnds |-> busyLowCount == (CW+1)'(BUSY_SPAN))
        else $error("busy low span wrong");

    a_result_stable: assert property (
        @(posedge clock) disable iff (reset)
        s_latchIdle |=> $stable(result))
        else $error("result changed outside latch");

    a_start_needs_req: assert property (
        @(posedge clock) disable iff (reset)
        s_start |-> s_freshReq)
        else $error("start without fresh request");

    a_lsb_line: assert property (
        @(posedge clock) disable iff (reset)
        readEnable |=> dataOut[`SAPP_PAD_W] == $past(result[0]))
        else $error("result lsb misplaced");

    a_low_byte_kept: assert property (
        @(posedge clock) disable iff (reset)
        byteSync |=> dataOut[`SAPP_BYTE_W-1:0]
                     == {$past(result[`SAPP_BYTE_W-`SAPP_PAD_W-1:0]), {`SAPP_PAD_W{1'b0}}})
        else $error("lower byte moved");

    a_float_on_request: assert property (
        @(posedge clock) disable iff (reset)
        convReq |=> dataOe == '0)
        else $error("bus driven while converting");
endmodule

// >>> tb/sapp_host.sv
// host controller model for the converter port
// assumes the bench calls its tasks; pins change just after a rising edge
module sapp_host (
    // clock
    input  wire logic clock,
    // control pins
    output logic      selectN,
    output logic      readConvert,
    output logic      byteSelect,
    // status pin
    input  wire logic busyN
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] busySync = 2'b11;

    initial
    begin
        selectN = 1'b1;
        readConvert = 1'b1;
        byteSelect = 1'b0;
    end

    always_ff @(posedge clock)
        busySync <= {busySync[0], busyN};

    // one input low first, the other falls a cycle later
    task automatic convert(input logic viaSelect);
        @(posedge clock);
        if (viaSelect)
            readConvert <= 1'b0;
        else
            selectN <= 1'b0;
        @(posedge clock);
        selectN <= 1'b0;
        readConvert <= 1'b0;
        repeat (3) @(posedge clock);
        readConvert <= 1'b1;
    endtask

    task automatic idle();
        @(posedge clock);
        selectN <= 1'b1;
    endtask

    task automatic setByte(input logic low);
        @(posedge clock);
        byteSelect <= low;
    endtask
endmodule

// >>> tb/sapp_port_test.sv
// self-checking bench of the converter host port
// assumes a 10 MHz clock and a shortened conversion count
`include "sapp_defs.svh"
`define CHECK(what, exp, got) \
    samplesChecked++; \
    if ((got) !== (exp)) \
    begin \
        failures++; \
        $display("Error %s expected %h seen %h", what, exp, got); \
    end

module sapp_port_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic                   clock = 1'b0;
    logic                   reset = 1'b1;
    logic [`SAPP_RES_W-1:0] sample = 12'h000;
    logic [`SAPP_RES_W-1:0] previous = 12'h000;
    logic [`SAPP_RES_W-1:0] codes [5] = '{12'h7ff, 12'h000, 12'hfff, 12'h800, 12'ha5c};
    logic                   selectN;
    logic                   readConvert;
    logic                   byteSelect;
    logic                   busyN;
    logic [`SAPP_BUS_W-1:0] dataOut;
    logic [`SAPP_BUS_W-1:0] dataOe;
    int                     failures = 0;
    int                     samplesChecked = 0;

    sapp_port #(.CONV_CYCLES(20)) i_sapp_port (
        .clock       (clock),
        .reset       (reset),
        .selectN     (selectN),
        .readConvert (readConvert),
        .byteSelect  (byteSelect),
        .sample      (sample),
        .busyN       (busyN),
        .dataOut     (dataOut),
        .dataOe      (dataOe)
    );

    sapp_host i_sapp_host (
        .clock       (clock),
        .selectN     (selectN),
        .readConvert (readConvert),
        .byteSelect  (byteSelect),
        .busyN       (busyN)
    );

    initial
    begin
        forever #50 clock = ~clock;
    end

    task automatic conclude();
        $display("failures %0d samplesChecked %0d", failures, samplesChecked);
        if (failures == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic settle(input int cycles);
        repeat (cycles) @(posedge clock);
        #1;
    endtask

    // waits for the host's synchronised busy to reach a level, giving up after 60 cycles
    task automatic waitBusy(input logic level);
        for (int i = 0; i < 60 && i_sapp_host.busySync[1] !== level; i++)
            settle(1);
    endtask

    task automatic convertRead(input logic [11:0] code, input logic viaSelect);
        @(posedge clock);
        sample <= code;
        i_sapp_host.idle();
        i_sapp_host.convert(viaSelect);
        settle(1);
        `CHECK("busy", 1'b0, busyN)
        `CHECK("oe converting", 16'h0000, dataOe)
        settle(3);
        `CHECK("oe reading", 16'hffff, dataOe)
        `CHECK("old word", {previous, 4'h0}, dataOut)
        waitBusy(1'b1);
        previous = code;
        settle(1);
        `CHECK("busy done", 1'b1, busyN)
        `CHECK("word", {code, 4'h0}, dataOut)
        i_sapp_host.setByte(1'b1);
        settle(4);
        `CHECK("bytes", {code[3:0], 4'h0, code[3:0], 4'h0}, dataOut)
        i_sapp_host.setByte(1'b0);
        i_sapp_host.idle();
        settle(4);
        `CHECK("oe idle", 16'h0000, dataOe)
        settle(100);
    endtask

    // second request falls inside the busy time with a new sample waiting
    task automatic ignoredRequest();
        @(posedge clock);
        sample <= codes[0];
        i_sapp_host.idle();
        i_sapp_host.convert(1'b0);
        sample <= codes[4];
        i_sapp_host.convert(1'b0);
        waitBusy(1'b1);
        settle(30);
        `CHECK("busy ignored", 1'b1, busyN)
        `CHECK("word ignored", {codes[0], 4'h0}, dataOut)
        i_sapp_host.idle();
        settle(100);
    endtask

    initial
    begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        settle(1);
        `CHECK("busy reset", 1'b1, busyN)
        `CHECK("oe reset", 16'h0000, dataOe)
        foreach (codes[i])
            convertRead(codes[i], i[0]);
        ignoredRequest();
        conclude();
    end

    initial
    begin
        settle(5000);
        failures++;
        conclude();
    end
endmodule
